// ==== ipcw_regs.svh ====
// Register offsets, field positions, reset values and key codes
// for the interrupt pin configuration and write lock block.
// Assumes inclusion by the design modules only.
`ifndef IPCW_REGS_SVH
`define IPCW_REGS_SVH

// Register indices; the APB byte address is the index times four
`define IPCW_IDX_INT_CFG 8'h7D
`define IPCW_IDX_PROT_KEY 8'h7E
`define IPCW_IDX_SCRATCH 8'h7F
`define IPCW_IDX_IRQ_STAT 8'h80
`define IPCW_IDX_IRQ_MASK 8'h81
`define IPCW_IDX_PIN_STAT 8'h82

// Fields of interrupt_output_config
`define IPCW_BIT_POLARITY 0
`define IPCW_BIT_TRISTATE 1
`define IPCW_BIT_GPO_SEL 2

// Reset values
`define IPCW_RST_INT_CFG 8'h02
`define IPCW_RST_PROT_KEY 8'h85
`define IPCW_RST_SCRATCH 8'h00
`define IPCW_RST_IRQ_MASK 2'h0

// Key codes
`define IPCW_KEY_FULL 8'h85
`define IPCW_KEY_SINGLE 8'h86

// Status bit positions
`define IPCW_STAT_BLOCKED 0
`define IPCW_STAT_SRC 1

`endif

// ==== ipcw_pkg.sv ====
// Types shared by the interrupt pin configuration and write lock block.
// Assumes nothing beyond the register header.
package ipcw_pkg;
  typedef enum logic [1:0] {
    IPCW_LOCKED = 2'b00,
    IPCW_OPEN = 2'b01,
    IPCW_ONE_SHOT = 2'b10
  } ipcw_lock_mode_t;
endpackage : ipcw_pkg

// ==== ipcw_pin_drive.sv ====
// Interrupt pin driver: active level, general output use and tristate.
// Assumes a single clock; all outputs are registered.
`timescale 1ns/1ps
`include "ipcw_regs.svh"

module ipcw_pin_drive
  import ipcw_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] cfg_in,
  input wire logic irq_in,
  output logic pin_o_out,
  output logic pin_oe_out,
  output logic pin_active_out
);
  logic polarity;
  logic tristate;
  logic gpo_sel;
  logic active;
  logic level_d;
  logic oe_d;

  assign polarity = cfg_in[`IPCW_BIT_POLARITY];
  assign tristate = cfg_in[`IPCW_BIT_TRISTATE];
  assign gpo_sel = cfg_in[`IPCW_BIT_GPO_SEL];
  assign active = gpo_sel ? 1'b1 : irq_in;
  assign level_d = gpo_sel ? polarity : (active ? polarity : ~polarity);
  assign oe_d = tristate ? active : 1'b1;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_o_out <= 1'b1;
      pin_oe_out <= 1'b0;
      pin_active_out <= 1'b0;
    end else begin
      pin_o_out <= level_d;
      pin_oe_out <= oe_d;
      pin_active_out <= active;
    end
  end
endmodule : ipcw_pin_drive

// ==== ipcw_top.sv ====
// Interrupt pin configuration and register write lock behind an APB slave.
// Assumes one 25 MHz clock, synchronous active-high reset, APB master.
//
// Functional notes
// - Config bit 2 low: pin carries interrupt; high: pin drives active level.
// - Bit 1 low: pin always driven; high: driven only while active.
// - Config register resets to 0x02: interrupt use, tristate, active low.
// - Writes to config, scratch and mask need key 0x85 (any) or 0x86 (one).
// - Protection key resets to 0x85, so writes are accepted after reset.
`timescale 1ns/1ps
`include "ipcw_regs.svh"

module ipcw_top
  import ipcw_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Interrupt source from the timing core
  input wire logic IRQ_SRC_IN,
  // Interrupt pin, two signals
  output logic IRQ_PIN_O_OUT,
  output logic IRQ_PIN_OE_OUT,
  // Block interrupt
  output logic IRQ_OUT
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] int_cfg_q;
  logic [7:0] int_cfg_d;
  logic [7:0] prot_key_q;
  logic [7:0] prot_key_d;
  logic [7:0] scratch_q;
  logic [7:0] scratch_d;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_stat_d;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_mask_d;
  logic src_q;
  logic [31:0] rdata_d;
  logic ready_d;
  logic slverr_d;
  logic irq_d;
  logic pin_active;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  function automatic logic addr_is(input logic [11:0] addr, input logic [7:0] idx);
    addr_is = (addr == {2'h0, idx, 2'h0});
  endfunction : addr_is

  wire setup = PSEL_IN && !PENABLE_IN;
  // Answer one cycle after setup; access ends with PREADY high
  wire access = PSEL_IN && PENABLE_IN && PREADY_OUT;
  wire wr = access && PWRITE_IN;
  wire rd = access && !PWRITE_IN;
  wire hit_cfg = addr_is(PADDR_IN, `IPCW_IDX_INT_CFG);
  wire hit_key = addr_is(PADDR_IN, `IPCW_IDX_PROT_KEY);
  wire hit_scr = addr_is(PADDR_IN, `IPCW_IDX_SCRATCH);
  wire hit_stat = addr_is(PADDR_IN, `IPCW_IDX_IRQ_STAT);
  wire hit_mask = addr_is(PADDR_IN, `IPCW_IDX_IRQ_MASK);
  wire hit_pin = addr_is(PADDR_IN, `IPCW_IDX_PIN_STAT);
  wire hit_any = hit_cfg || hit_key || hit_scr || hit_stat || hit_mask || hit_pin;

  ////////////////////////////////////////////////////////////////////////
  // Write lock
  // decode of lock mode
  wire ipcw_lock_mode_t lock_mode = (prot_key_q == `IPCW_KEY_FULL) ? IPCW_OPEN :
                                    (prot_key_q == `IPCW_KEY_SINGLE) ? IPCW_ONE_SHOT :
                                    IPCW_LOCKED;
  wire unlocked = (lock_mode != IPCW_LOCKED);
  // Key and status registers are never locked, or software could not unlock
  wire lockable = hit_cfg || hit_scr || hit_mask;
  wire wr_ok = wr && lockable && unlocked;
  wire wr_blocked = wr && lockable && !unlocked;
  wire relock = wr_ok && (lock_mode == IPCW_ONE_SHOT);

  assign int_cfg_d = (wr_ok && hit_cfg) ? {5'h00, PWDATA_IN[2:0]} : int_cfg_q;
  assign scratch_d = (wr_ok && hit_scr) ? PWDATA_IN[7:0] : scratch_q;
  assign irq_mask_d = (wr_ok && hit_mask) ? PWDATA_IN[1:0] : irq_mask_q;
  // Relock writes zero, a protected code
  assign prot_key_d = (wr && hit_key) ? PWDATA_IN[7:0] :
                      relock ? 8'h00 : prot_key_q;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over read-clear
  wire src_rise = IRQ_SRC_IN && !src_q;
  wire [1:0] ev = {src_rise, wr_blocked};
  wire [1:0] stat_clr = (rd && hit_stat) ? 2'h3 : 2'h0;
  assign irq_stat_d = (irq_stat_q & ~stat_clr) | ev;
  assign irq_d = |(irq_stat_d & irq_mask_d);

  ////////////////////////////////////////////////////////////////////////
  // Read data and answer
  wire [31:0] rd_mux = hit_cfg ? {24'h000000, int_cfg_q} :
                       hit_key ? {24'h000000, prot_key_q} :
                       hit_scr ? {24'h000000, scratch_q} :
                       hit_stat ? {30'h0, irq_stat_q} :
                       hit_mask ? {30'h0, irq_mask_q} :
                       hit_pin ? {29'h0, pin_active, unlocked, IRQ_SRC_IN} :
                       32'h00000000;
  assign ready_d = setup;
  assign rdata_d = (setup && !PWRITE_IN) ? rd_mux : 32'h00000000;
  assign slverr_d = setup && !hit_any;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      int_cfg_q <= `IPCW_RST_INT_CFG;
      prot_key_q <= `IPCW_RST_PROT_KEY;
      scratch_q <= `IPCW_RST_SCRATCH;
      irq_mask_q <= `IPCW_RST_IRQ_MASK;
      irq_stat_q <= 2'h0;
      src_q <= 1'b0;
      PRDATA_OUT <= 32'h00000000;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      IRQ_OUT <= 1'b0;
    end else begin
      int_cfg_q <= int_cfg_d;
      prot_key_q <= prot_key_d;
      scratch_q <= scratch_d;
      irq_mask_q <= irq_mask_d;
      irq_stat_q <= irq_stat_d;
      src_q <= IRQ_SRC_IN;
      PRDATA_OUT <= rdata_d;
      PREADY_OUT <= ready_d;
      PSLVERR_OUT <= slverr_d;
      IRQ_OUT <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin driver
  // pin driven from config
  ipcw_pin_drive u_pin (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .cfg_in(int_cfg_q),
    .irq_in(IRQ_SRC_IN),
    .pin_o_out(IRQ_PIN_O_OUT),
    .pin_oe_out(IRQ_PIN_OE_OUT),
    .pin_active_out(pin_active)
  );

endmodule : ipcw_top

// ==== ipcw_monitor.sv ====
// Port assertions for the pin config and write lock block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module ipcw_monitor (
  input wire logic CLK_IN, RST_IN, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT,
  input wire logic PSLVERR_OUT, IRQ_SRC_IN, IRQ_PIN_O_OUT, IRQ_PIN_OE_OUT, IRQ_OUT,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN, PRDATA_OUT
);
  wire setup = PSEL_IN && !PENABLE_IN;
  wire mapped = PADDR_IN >= 12'h1F4 && PADDR_IN <= 12'h208 && PADDR_IN[1:0] == 2'h0;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  ready_after_setup_a: assert property (setup |=> PREADY_OUT)
    else $error("ready missing after setup");
  ready_single_a: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held too long");
  error_with_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
    else $error("error without ready");
  unmapped_error_a: assert property (setup && !mapped |=> PSLVERR_OUT)
    else $error("unmapped address not flagged");
  mapped_no_error_a: assert property (setup && mapped |=> !PSLVERR_OUT)
    else $error("mapped address flagged");
  read_data_idle_a: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
    else $error("read data outside ready");
  upper_bits_zero_a: assert property (PREADY_OUT |-> PRDATA_OUT[31:8] == 24'h0)
    else $error("upper read bits set");
  reset_tristate_a: assert property (disable iff (1'b0)
    RST_IN && !IRQ_SRC_IN |=> !IRQ_PIN_OE_OUT && !IRQ_OUT) else $error("pin driven in reset");
endmodule : ipcw_monitor

// ==== ipcw_host_pin.sv ====
// Host side of the interrupt line.
// Assumes a board pull-up holds the line high when nobody drives it.
`timescale 1ns/1ps
module ipcw_host_pin (
  input wire logic o_in,
  input wire logic oe_in,
  output logic pin_out
);
  assign pin_out = oe_in ? o_in : 1'b1;
endmodule : ipcw_host_pin

// ==== ipcw_tb.sv ====
// Bench for the pin config and write lock block.
// Assumes the monitor and host pin model are compiled first.
`timescale 1ns/1ps
`define CHK(n,g,e) begin num_checks++; if ((g)!==(e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module testbench;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, src = 0;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, e;
  logic [31:0] q[$];
  logic [7:0] k;
  wire [31:0] prd;
  wire rdy, err, po, poe, irq, pin;
  int err_count = 0, num_checks = 0;
  ipcw_top i_ipcw_top(.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(rdy),
    .PSLVERR_OUT(err), .IRQ_SRC_IN(src), .IRQ_PIN_O_OUT(po), .IRQ_PIN_OE_OUT(poe),
    .IRQ_OUT(irq));
  ipcw_host_pin i_ipcw_host_pin(.o_in(po), .oe_in(poe), .pin_out(pin));
  initial forever #20 clk = ~clk;
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (rdy !== 1'b1);
    psel <= 0; pen <= 0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    q.push_back({24'h0, x});
    apb(0, a, 8'h0);
  endtask : rd
  task automatic pin_is(input logic eo, input logic eoe);
    repeat (3) @(posedge clk);
    `CHK("pin", pin, eo)
    `CHK("oe", poe, eoe)
  endtask : pin_is
  always @(posedge clk) if (psel && pen && rdy && !pwr) begin
    e = q.pop_front();
    `CHK("rdata", prd, e)
  end
  initial begin
    #100us err_count++;
    results;
  end
  initial begin
    void'($urandom(73));
    repeat (10) @(posedge clk);
    rst <= 0;
    rd(12'h1F4, 8'h02);
    rd(12'h1F8, 8'h85);
    rd(12'h300, 8'h00);
    $display("reset values done");
    src <= 1; pin_is(0, 1);
    src <= 0; pin_is(1, 0);
    apb(1, 12'h1F4, 8'h00); pin_is(1, 1);
    src <= 1; pin_is(0, 1);
    apb(1, 12'h1F4, 8'h01); pin_is(1, 1);
    src <= 0; pin_is(0, 1);
    apb(1, 12'h1F4, 8'h04); pin_is(0, 1);
    apb(1, 12'h1F4, 8'h05); pin_is(1, 1);
    $display("pin modes done");
    apb(1, 12'h204, 8'h03);
    rd(12'h200, 8'h02);
    k = $urandom;
    if (k == 8'h85 || k == 8'h86) k = 8'h84;
    apb(1, 12'h1F8, k);
    apb(1, 12'h1F4, 8'h00);
    repeat (2) @(posedge clk);
    `CHK("irq", irq, 1'b1)
    rd(12'h1F4, 8'h05);
    rd(12'h200, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("irq", irq, 1'b0)
    apb(1, 12'h1F8, 8'h86);
    apb(1, 12'h204, 8'h00);
    apb(1, 12'h1F4, 8'h02);
    rd(12'h1F8, 8'h00);
    rd(12'h1F4, 8'h05);
    `CHK("irq", irq, 1'b0)
    $display("lock modes done");
    results;
  end
endmodule : testbench
bind ipcw_top ipcw_monitor i_ipcw_monitor(.CLK_IN, .RST_IN, .PSEL_IN, .PENABLE_IN,
  .PWRITE_IN, .PREADY_OUT, .PSLVERR_OUT, .IRQ_SRC_IN, .IRQ_PIN_O_OUT, .IRQ_PIN_OE_OUT,
  .IRQ_OUT, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT);
